//--- rtl/parity_xcvr.sv
/*
  Eight-bit bus transceiver with odd parity generation, parity check and a
  sticky error flag, plus an APB register block with a masked interrupt.
  Assumes all pins are synchronous to pclk and an external pull-up on the
  open-drain error line.
*/
`timescale 1ns/100ps
`default_nettype none
`include "parity_xcvr_consts.svh"

module parity_xcvr
  import parity_xcvr_pkg::*;
#(
  parameter int DATA_W = `PX_DATA_W
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              a_side_drive_enable_n,
  input  wire logic              b_side_drive_enable_n,
  input  wire logic              fault_clear_n,
  input  wire logic              flag_clk,
  input  wire logic [DATA_W-1:0] a_bus_bit_in,
  output logic      [DATA_W-1:0] a_bus_bit_out,
  output logic      [DATA_W-1:0] a_bus_oe_n,
  input  wire logic [DATA_W-1:0] b_bus_bit_in,
  output logic      [DATA_W-1:0] b_bus_bit_out,
  output logic      [DATA_W-1:0] b_bus_oe_n,
  input  wire logic              parity_in,
  output logic                   parity_out,
  output logic                   parity_oe_n,
  input  wire logic              fault_in,
  output logic                   fault_out,
  output logic                   fault_oe_n,
  output logic                   irq
);

  function automatic mode_e decode_mode(input logic a_en_n,
                                        input logic b_en_n);
    mode_e m;
    case ({b_en_n, a_en_n})
      2'b01:   m = MODE_A_TO_B;
      2'b10:   m = MODE_B_TO_A;
      2'b11:   m = MODE_ISOLATE;
      default: m = MODE_FORCED;
    endcase
    return m;
  endfunction : decode_mode

  // High when the vector holds an odd count of ones
  function automatic logic odd_ones(input logic [DATA_W:0] v);
    return ^v;
  endfunction : odd_ones

  mode_e              mode;
  logic               a_odd;
  logic               b_nine_odd;

  assign mode       = decode_mode(a_side_drive_enable_n,
                                  b_side_drive_enable_n);
  assign a_odd      = odd_ones({1'b0, a_bus_bit_in});
  assign b_nine_odd = odd_ones({parity_in, b_bus_bit_in});

  // Bus drivers
  logic [DATA_W-1:0] a_out_reg, a_out_next, a_oe_reg, a_oe_next;
  logic [DATA_W-1:0] b_out_reg, b_out_next, b_oe_reg, b_oe_next;
  logic              par_reg, par_next, par_oe_reg, par_oe_next;

  always_comb begin
    a_out_next  = a_out_reg;
    b_out_next  = b_out_reg;
    par_next    = par_reg;
    a_oe_next   = '1;
    b_oe_next   = '1;
    par_oe_next = 1'b1;
    case (mode)
      MODE_A_TO_B: begin
        b_out_next  = a_bus_bit_in;
        b_oe_next   = '0;
        par_next    = ~a_odd;
        par_oe_next = 1'b0;
      end
      MODE_B_TO_A: begin
        a_out_next = b_bus_bit_in;
        a_oe_next  = '0;
      end
      MODE_FORCED: begin
        b_out_next  = a_bus_bit_in;
        b_oe_next   = '0;
        par_next    = a_odd;
        par_oe_next = 1'b0;
      end
      MODE_ISOLATE: begin
        a_oe_next   = '1;
        b_oe_next   = '1;
        par_oe_next = 1'b1;
      end
      default: begin
        a_oe_next = '1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_out_reg  <= '0;
      b_out_reg  <= '0;
      par_reg    <= 1'b0;
      a_oe_reg   <= '1;
      b_oe_reg   <= '1;
      par_oe_reg <= 1'b1;
    end else begin
      a_out_reg  <= a_out_next;
      b_out_reg  <= b_out_next;
      par_reg    <= par_next;
      a_oe_reg   <= a_oe_next;
      b_oe_reg   <= b_oe_next;
      par_oe_reg <= par_oe_next;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_pins
      assign a_bus_bit_out[gi] = a_out_reg[gi];
      assign a_bus_oe_n[gi]    = a_oe_reg[gi];
      assign b_bus_bit_out[gi] = b_out_reg[gi];
      assign b_bus_oe_n[gi]    = b_oe_reg[gi];
    end
  endgenerate

  assign parity_out  = par_reg;
  assign parity_oe_n = par_oe_reg;

  // Error flag
  logic flag_reg, flag_next, fclk_reg;
  logic soft_clear, soft_sample, clear_act, sample, check_pass, check_mode;

  assign clear_act  = !fault_clear_n || soft_clear;
  assign sample     = (flag_clk && !fclk_reg) || soft_sample;
  // Other modes have no defined check, so the flag simply holds there
  assign check_mode = (mode == MODE_B_TO_A) || (mode == MODE_ISOLATE);
  assign check_pass = (mode == MODE_ISOLATE) ? a_odd : b_nine_odd;

  always_comb begin
    flag_next = flag_reg;
    if (clear_act)
      flag_next = 1'b1;
    else if (sample && check_mode)
      flag_next = check_pass && flag_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= `PX_FLAG_RST;
      fclk_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      fclk_reg <= flag_clk;
    end
  end

  // fault_clear_n releases the line in the same cycle; soft clear releases it one edge later, when flag_reg sets
  assign fault_out  = 1'b0;
  assign fault_oe_n = flag_reg || !fault_clear_n;

  // APB slave, zero wait states
  logic [`PX_INT_W-1:0] int_stat_reg, int_stat_next;
  logic [`PX_INT_W-1:0] int_mask_reg, int_mask_next;
  logic [31:0]          rdata_reg, rdata_next;
  logic                 err_reg, err_next;
  logic                 sclear_reg, sclear_next, smp_reg, smp_next;
  logic                 wr, rd, hit;
  logic [`PX_INT_W-1:0] events;
  mode_e                mode_reg;

  assign wr  = psel && penable && pwrite;
  assign rd  = psel && !penable && !pwrite;
  assign hit = (paddr == `PX_OFF_CTRL) || (paddr == `PX_OFF_STATUS) ||
               (paddr == `PX_OFF_INT_STAT) || (paddr == `PX_OFF_INT_MASK);
  assign soft_clear  = sclear_reg;
  assign soft_sample = smp_reg;

  always_comb begin
    events = '0;
    events[`PX_INT_ERR_BIT]   = flag_reg && !flag_next;
    events[`PX_INT_FORCE_BIT] = (mode == MODE_FORCED) &&
                                (mode_reg != MODE_FORCED);
  end

  always_comb begin
    int_mask_next = int_mask_reg;
    int_stat_next = int_stat_reg;
    sclear_next   = 1'b0;
    smp_next      = 1'b0;
    rdata_next    = rdata_reg;
    err_next      = 1'b0;
    if (wr && paddr == `PX_OFF_INT_STAT)
      int_stat_next = int_stat_reg & ~pwdata[`PX_INT_W-1:0];
    // A new event outranks a write-one-to-clear in the same cycle
    int_stat_next = int_stat_next | events;
    if (wr && paddr == `PX_OFF_INT_MASK)
      int_mask_next = pwdata[`PX_INT_W-1:0];
    if (wr && paddr == `PX_OFF_CTRL) begin
      sclear_next = pwdata[`PX_CTRL_CLEAR_BIT];
      smp_next = pwdata[`PX_CTRL_SAMPLE_BIT];
    end
    if (psel && !penable) begin
      err_next = !hit;
      if (rd) begin
        rdata_next = '0;
        case (paddr)
          `PX_OFF_STATUS: begin
            rdata_next[`PX_ST_FLAG_BIT] = flag_reg;
            rdata_next[`PX_ST_LINE_BIT] = fault_in;
            rdata_next[`PX_ST_MODE_LSB +: 2] = mode;
          end
          `PX_OFF_INT_STAT: rdata_next[`PX_INT_W-1:0] = int_stat_reg;
          `PX_OFF_INT_MASK: rdata_next[`PX_INT_W-1:0] = int_mask_reg;
          default:          rdata_next = '0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_reg <= '0;
      int_mask_reg <= `PX_INT_MASK_RST;
      sclear_reg   <= 1'b0;
      smp_reg      <= 1'b0;
      rdata_reg    <= '0;
      err_reg      <= 1'b0;
      mode_reg     <= MODE_ISOLATE;
    end else begin
      int_stat_reg <= int_stat_next;
      int_mask_reg <= int_mask_next;
      sclear_reg   <= sclear_next;
      smp_reg      <= smp_next;
      rdata_reg    <= rdata_next;
      err_reg      <= err_next;
      mode_reg     <= mode;
    end
  end

  assign prdata  = rdata_reg;
  assign pready  = 1'b1;
  assign pslverr = err_reg && psel && penable;
  assign irq     = |(int_stat_reg & int_mask_reg);

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_check_edge;
    sample && fault_clear_n && !soft_clear && mode == MODE_B_TO_A;
  endsequence

  sequence s_iso_edge;
    sample && fault_clear_n && !soft_clear && mode == MODE_ISOLATE;
  endsequence

  a_iso_release: assert property (mode == MODE_ISOLATE |=>
      (&a_bus_oe_n) && (&b_bus_oe_n) && parity_oe_n)
    else $error("buses driven in isolation");

  a_gen_parity: assert property (mode == MODE_A_TO_B |=>
      parity_out == !(^$past(a_bus_bit_in)) && !parity_oe_n)
    else $error("generated parity not odd");

  a_a_to_b: assert property (mode == MODE_A_TO_B |=>
      b_bus_bit_out == $past(a_bus_bit_in) && (b_bus_oe_n == '0) &&
      (&a_bus_oe_n))
    else $error("A to B path wrong");

  a_b_to_a: assert property (mode == MODE_B_TO_A |=>
      a_bus_bit_out == $past(b_bus_bit_in) && (a_bus_oe_n == '0) &&
      (&b_bus_oe_n) && parity_oe_n)
    else $error("B to A path wrong");

  a_forced_par: assert property (mode == MODE_FORCED |=>
      parity_out == ^$past(a_bus_bit_in) &&
      b_bus_bit_out == $past(a_bus_bit_in))
    else $error("forced parity not inverted");

  a_check_err: assert property (s_check_edge ##0
      !(^{parity_in, b_bus_bit_in}) |=> !flag_reg &&
      (!fault_oe_n || !fault_clear_n))
    else $error("even B count did not flag");

  a_iso_sample: assert property (s_iso_edge |=>
      flag_reg == ($past(a_odd) && $past(flag_reg)))
    else $error("isolation sample wrong");

  a_flag_hold: assert property (!sample && fault_clear_n &&
      !soft_clear |=> $stable(flag_reg))
    else $error("flag moved without edge");

  a_flag_sticky: assert property ((!flag_reg && fault_clear_n &&
      !soft_clear) |=> !flag_reg)
    else $error("error flag not held");

  a_clear_force: assert property (!fault_clear_n |-> fault_oe_n
      ##1 flag_reg)
    else $error("clear did not raise flag");

  a_soft_clear: assert property (soft_clear |=> flag_reg)
    else $error("soft clear did not raise flag");

  a_forced_oe: assert property (mode == MODE_FORCED |=>
      (b_bus_oe_n == '0) && !parity_oe_n && (&a_bus_oe_n))
    else $error("forced mode drivers wrong");

  a_forced_event: assert property (mode == MODE_FORCED &&
      mode_reg != MODE_FORCED |=> int_stat_reg[`PX_INT_FORCE_BIT])
    else $error("forced entry event lost");

  a_open_drain: assert property (fault_out == 1'b0)
    else $error("error line driven high");

endmodule : parity_xcvr

`default_nettype wire

//--- common/parity_xcvr_consts.svh
/*
  Offsets, field positions and reset values of the parity transceiver.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef PARITY_XCVR_CONSTS_SVH
`define PARITY_XCVR_CONSTS_SVH

`define PX_DATA_W          8
`define PX_ADDR_W          12
`define PX_OFF_CTRL        12'h000
`define PX_OFF_STATUS      12'h004
`define PX_OFF_INT_STAT    12'h008
`define PX_OFF_INT_MASK    12'h00C
`define PX_CTRL_CLEAR_BIT  0
`define PX_CTRL_SAMPLE_BIT 1
`define PX_ST_FLAG_BIT     0
`define PX_ST_LINE_BIT     1
`define PX_ST_MODE_LSB     2
`define PX_INT_ERR_BIT     0
`define PX_INT_FORCE_BIT   1
`define PX_INT_W           2
`define PX_INT_MASK_RST    2'h0
`define PX_FLAG_RST        1'b1

`endif

//--- common/parity_xcvr_pkg.sv
/*
  Types shared by the parity transceiver design.
  Assumes the constants header is on the include path.
*/
`include "parity_xcvr_consts.svh"

package parity_xcvr_pkg;

  typedef enum logic [1:0] {
    MODE_A_TO_B,
    MODE_B_TO_A,
    MODE_ISOLATE,
    MODE_FORCED
  } mode_e;

  typedef logic [`PX_ADDR_W-1:0] addr_t;

endpackage : parity_xcvr_pkg

//--- testbench/bus_partner.sv
/*
  Far-side bus logic on the A bus, the B bus, parity and the error wire.
  Assumes the testbench supplies what the far side puts on each bus.
*/
`timescale 1ns/100ps
`default_nettype none

module bus_partner (
  input  wire logic [7:0] a_drive,
  input  wire logic [7:0] b_drive,
  input  wire logic       par_drive,
  input  wire logic [7:0] a_out,
  input  wire logic [7:0] a_oe_n,
  input  wire logic [7:0] b_out,
  input  wire logic [7:0] b_oe_n,
  input  wire logic       par_out,
  input  wire logic       par_oe_n,
  input  wire logic       flt_out,
  input  wire logic       flt_oe_n,
  output logic      [7:0] a_wire,
  output logic      [7:0] b_wire,
  output logic            par_wire,
  output logic            flt_wire
);
  // Far side drives only bits the device has let go, so no contention
  assign a_wire   = (a_oe_n & a_drive) | (~a_oe_n & a_out);
  assign b_wire   = (b_oe_n & b_drive) | (~b_oe_n & b_out);
  assign par_wire = par_oe_n ? par_drive : par_out;
  // Pull-up holds the shared error wire high when released
  assign flt_wire = flt_oe_n ? 1'b1 : flt_out;
endmodule : bus_partner

`default_nettype wire

//--- testbench/testbench.sv
/*
  Self-checking bench for the parity transceiver: pins and APB registers.
  Assumes bus_partner models the logic on the far side of both buses.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import parity_xcvr_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        a_en_n, b_en_n, fclear_n, flag_clk, err;
  logic [7:0]  a_drv, b_drv, a_in, a_out, a_oe_n, b_in, b_out, b_oe_n;
  logic        p_drv, par_in, par_out, par_oe_n, flt_in, flt_out, flt_oe_n;
  int          bad_count, comparisons;

  parity_xcvr u_parity_xcvr (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .a_side_drive_enable_n(a_en_n), .b_side_drive_enable_n(b_en_n),
    .fault_clear_n(fclear_n), .flag_clk(flag_clk),
    .a_bus_bit_in(a_in), .a_bus_bit_out(a_out), .a_bus_oe_n(a_oe_n),
    .b_bus_bit_in(b_in), .b_bus_bit_out(b_out), .b_bus_oe_n(b_oe_n),
    .parity_in(par_in), .parity_out(par_out), .parity_oe_n(par_oe_n),
    .fault_in(flt_in), .fault_out(flt_out), .fault_oe_n(flt_oe_n),
    .irq(irq));

  bus_partner u_bus_partner (
    .a_drive(a_drv), .b_drive(b_drv), .par_drive(p_drv),
    .a_out(a_out), .a_oe_n(a_oe_n), .b_out(b_out), .b_oe_n(b_oe_n),
    .par_out(par_out), .par_oe_n(par_oe_n), .flt_out(flt_out),
    .flt_oe_n(flt_oe_n), .a_wire(a_in), .b_wire(b_in),
    .par_wire(par_in), .flt_wire(flt_in));

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic finish_test;
    if (bad_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // Every driving task starts on a rising edge and ends on a falling one
  task automatic apb(input logic wr, input logic [11:0] addr,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) begin
        bad_count++;
        finish_test();
      end
    end while (pready !== 1'b1);
    // Data and response are taken at the completing edge only
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask : apb

  // Outputs follow the pins one edge later; two edges leave margin
  task automatic pins(input logic eb, input logic ea, input logic [7:0] a,
                      input logic [7:0] b, input logic p);
    @(posedge pclk);
    b_en_n <= eb;
    a_en_n <= ea;
    a_drv <= a;
    b_drv <= b;
    p_drv <= p;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask : pins

  task automatic pulse;
    @(posedge pclk);
    flag_clk <= 1'b1;
    @(posedge pclk);
    flag_clk <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
  endtask : pulse

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    bad_count = 0;
    comparisons = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {a_en_n, b_en_n, fclear_n, flag_clk} = 4'b1110;
    {a_drv, b_drv, p_drv} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("reset fault_oe_n", 1, flt_oe_n);
    pins(1'b0, 1'b1, 8'h01, 8'h00, 1'b0);
    chk("b_out", 8'h01, b_out);
    chk("oe a b", 16'hFF00, {a_oe_n, b_oe_n});
    chk("parity odd a", 0, {par_oe_n, par_out});
    pins(1'b0, 1'b1, 8'h03, 8'h00, 1'b0);
    chk("parity even a", 1, {par_oe_n, par_out});
    pins(1'b0, 1'b0, 8'h01, 8'h00, 1'b0);
    chk("forced odd a", 3, {par_oe_n, par_out, b_out == 8'h01});
    pins(1'b0, 1'b0, 8'h03, 8'h00, 1'b0);
    chk("forced even a", 0, {par_oe_n, par_out});
    pins(1'b1, 1'b0, 8'h00, 8'hA5, 1'b1);
    chk("a_out", 8'hA5, a_out);
    chk("oe b a", 16'hFF00, {b_oe_n, a_oe_n});
    pulse();
    chk("flag odd b", 1, flt_in);
    pins(1'b1, 1'b0, 8'h00, 8'hA5, 1'b0);
    chk("flag no edge", 1, flt_in);
    pulse();
    chk("flag even b", 0, flt_in);
    chk("fault drive", 0, {flt_oe_n, flt_out});
    pins(1'b1, 1'b0, 8'h00, 8'hA5, 1'b1);
    pulse();
    chk("flag sticky", 0, flt_in);
    apb(1'b0, 12'h004, 0);
    chk("status", 4'b0100, rd[3:0]);
    chk("irq masked", 0, irq);
    apb(1'b1, 12'h00C, 1);
    chk("irq unmasked", 1, irq);
    @(posedge pclk);
    fclear_n <= 1'b0;
    @(negedge pclk);
    chk("clear at once", 1, flt_in);
    @(posedge pclk);
    fclear_n <= 1'b1;
    apb(1'b0, 12'h008, 0);
    chk("int stat", 2'b11, rd[1:0]);
    apb(1'b1, 12'h008, 1);
    chk("irq cleared", 0, irq);
    pins(1'b1, 1'b1, 8'h01, 8'h00, 1'b0);
    chk("isolate oe", 17'h1FFFF, {a_oe_n, b_oe_n, par_oe_n});
    pulse();
    chk("isolate odd a", 1, flt_in);
    pins(1'b1, 1'b1, 8'h03, 8'h00, 1'b0);
    pulse();
    chk("isolate even a", 0, flt_in);
    apb(1'b1, 12'h000, 32'h0000_0001);
    @(negedge pclk);
    chk("soft clear", 1, flt_in);
    apb(1'b1, 12'h000, 32'h0000_0002);
    @(negedge pclk);
    chk("soft sample", 0, flt_in);
    apb(1'b0, 12'h010, 0);
    chk("unmapped", 1, err);
    finish_test();
  end
endmodule : testbench

`default_nettype wire
